// File: caju_pkg.sv
// package for the cpu addressing and jump unit: operations, modes, carriers, reset values
// assumes one core clock; opcode decoding is done ahead of this block
package caju_pkg;

  // decoded operations; encodings are local to this block
  typedef enum logic [5:0] {
    op_nop = 6'h00,
    op_load_acc = 6'h01,
    op_exchange = 6'h02,
    op_load_mem_imm = 6'h03,
    op_load_ptr_short = 6'h04,
    op_add = 6'h05,
    op_add_carry = 6'h06,
    op_subtract_borrow = 6'h07,
    op_and = 6'h08,
    op_or = 6'h09,
    op_xor = 6'h0a,
    op_increment = 6'h0b,
    op_decrement = 6'h0c,
    op_clear = 6'h0d,
    op_decimal_adjust = 6'h0e,
    op_carry_set_op = 6'h0f,
    op_carry_clear_op = 6'h10,
    op_rotate_right_carry = 6'h11,
    op_rotate_left_carry = 6'h12,
    op_swap_nibbles = 6'h13,
    op_if_equal = 6'h14,
    op_if_not_equal = 6'h15,
    op_if_greater = 6'h16,
    op_if_carry = 6'h17,
    op_if_no_carry = 6'h18,
    op_table_load_accumulator = 6'h19,
    op_short_relative_jump = 6'h1a,
    op_absolute_jump_12 = 6'h1b,
    op_long_absolute_jump = 6'h1c,
    op_table_indirect_jump = 6'h1d,
    op_subroutine_call = 6'h1e,
    op_long_subroutine_call = 6'h1f,
    op_subroutine_exit = 6'h20,
    op_subroutine_exit_skip = 6'h21,
    op_vector_interrupt_select = 6'h22
  } caju_op_t;

  // operand addressing modes
  typedef enum logic [2:0] {
    mode_none = 3'h0,
    mode_direct = 3'h1,
    mode_indirect = 3'h2,
    mode_post_inc = 3'h3,
    mode_post_dec = 3'h4,
    mode_imm = 3'h5
  } caju_mode_t;

  // one decoded instruction; field carries address, displacement or short value
  typedef struct packed {
    caju_op_t op;
    caju_mode_t mode;
    logic ptr_x;
    logic [1:0] len;
    logic [14:0] field;
  } caju_instr_t;

  // data memory request
  typedef struct packed {
    logic rd;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } caju_dm_req_t;

  localparam logic [7:0] pc_upper_reset = 8'h00;
  localparam logic [7:0] pc_low_reset = 8'h00;
  localparam logic [7:0] acc_reset = 8'h00;
  localparam logic [7:0] ptr_reset = 8'h00;
  localparam logic [7:0] sp_reset = 8'h6f;
  localparam logic [14:0] rel_bias = 15'h001f;
  localparam logic [3:0] short_imm_upper = 4'h0;
  localparam logic [7:0] ptr_step = 8'h01;
  localparam logic [7:0] frame_bytes = 8'h02;

endpackage

// File: caju_alu.sv
// accumulator arithmetic, logic, rotate and test evaluation, purely combinational
// assumes the caller registers the results and owns carry and half carry
`timescale 1ns/1ps
module caju_alu (
  // operation and inputs
  input wire caju_pkg::caju_op_t op,
  input wire logic [7:0] a,
  input wire logic [7:0] m,
  input wire logic c_in,
  input wire logic hc_in,
  input wire logic sub_in,
  // results
  output logic [7:0] res,
  output logic c_out,
  output logic hc_out,
  output logic wr_acc,
  output logic test,
  output logic cond
);
  logic [8:0] sum;
  logic [4:0] low;
  logic [7:0] mb;
  logic [7:0] dc;
  logic dcc;
  logic cin;

  always_comb begin
    // subtract is add of the complement plus carry, so carry set means no borrow
    mb = (op == caju_pkg::op_subtract_borrow) ? ~m : m;
    cin = (op == caju_pkg::op_add) ? 1'b0 : c_in;
    sum = {1'b0, a} + {1'b0, mb} + {8'h00, cin};
    low = {1'b0, a[3:0]} + {1'b0, mb[3:0]} + {4'h0, cin};
    dc = a;
    dcc = c_in;
    if (sub_in) begin
      if (!hc_in) dc = dc - 8'h06;
      if (!c_in) dc = dc - 8'h60;
    end else begin
      if (hc_in || a[3:0] > 4'h9) dc = dc + 8'h06;
      if (c_in || a > 8'h99) begin
        dc = dc + 8'h60;
        dcc = 1'b1;
      end
    end
  end

  always_comb begin
    res = a;
    c_out = c_in;
    hc_out = hc_in;
    wr_acc = 1'b1;
    test = 1'b0;
    cond = 1'b1;
    case (op)
      caju_pkg::op_add: res = sum[7:0];
      caju_pkg::op_add_carry, caju_pkg::op_subtract_borrow: begin
        res = sum[7:0];
        c_out = sum[8];
        hc_out = low[4];
      end
      caju_pkg::op_and: res = a & m;
      caju_pkg::op_or: res = a | m;
      caju_pkg::op_xor: res = a ^ m;
      caju_pkg::op_increment: res = a + 8'h01;
      caju_pkg::op_decrement: res = a - 8'h01;
      caju_pkg::op_clear: res = 8'h00;
      caju_pkg::op_decimal_adjust: begin
        res = dc;
        c_out = dcc;
      end
      caju_pkg::op_carry_set_op: c_out = 1'b1;
      caju_pkg::op_carry_clear_op: c_out = 1'b0;
      caju_pkg::op_rotate_right_carry: begin
        res = {c_in, a[7:1]};
        c_out = a[0];
      end
      caju_pkg::op_rotate_left_carry: begin
        res = {a[6:0], c_in};
        c_out = a[7];
      end
      caju_pkg::op_swap_nibbles: res = {a[3:0], a[7:4]};
      caju_pkg::op_load_acc, caju_pkg::op_exchange,
      caju_pkg::op_table_load_accumulator: res = m;
      caju_pkg::op_if_equal: begin
        wr_acc = 1'b0;
        test = 1'b1;
        cond = (a == m);
      end
      caju_pkg::op_if_not_equal: begin
        wr_acc = 1'b0;
        test = 1'b1;
        cond = (a != m);
      end
      caju_pkg::op_if_greater: begin
        wr_acc = 1'b0;
        test = 1'b1;
        cond = (a > m);
      end
      caju_pkg::op_if_carry: begin
        wr_acc = 1'b0;
        test = 1'b1;
        cond = c_in;
      end
      caju_pkg::op_if_no_carry: begin
        wr_acc = 1'b0;
        test = 1'b1;
        cond = !c_in;
      end
      default: wr_acc = 1'b0;
    endcase
  end
endmodule // caju_alu

// File: caju_core.sv
// operand addressing and program flow for the 8-bit accumulator core
// assumes program and data memory answer in the same cycle as a read strobe
`timescale 1ns/1ps
module caju_core (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // decoded instruction hand-in
  input wire logic instr_valid,
  input wire caju_pkg::caju_instr_t instr,
  output logic instr_ready,
  output logic done,
  // program memory
  output logic pm_rd,
  output logic [14:0] pm_addr,
  input wire logic [7:0] pm_rdata,
  // data memory
  output caju_pkg::caju_dm_req_t dm_req,
  input wire logic [7:0] dm_rdata,
  // visible state
  output logic [7:0] acc,
  output logic carry,
  output logic half_carry,
  output logic [7:0] first_pointer_reg,
  output logic [7:0] second_pointer_reg,
  output logic [7:0] stack_ptr,
  output logic [7:0] pc_upper_byte,
  output logic [7:0] pc_low_byte,
  output logic skip_pending
);
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_rd1 = 2'b01,
    st_rd2 = 2'b11,
    st_wr2 = 2'b10
  } caju_state_t;

  caju_state_t state, next_state;
  caju_pkg::caju_instr_t cur, ins;
  caju_pkg::caju_op_t op;
  logic take, skipping, now, needs_rd, is_call, is_pop, is_vec, src_pm;
  logic go_rd, go_call, go_quick, at1, at2, atw, src_pm_q, last_sub, ptr_mod;
  logic alu_c, alu_hc, alu_wr, alu_test, alu_cond;
  logic [14:0] pc15, link_addr, next_pc, pm_opnd_addr;
  logic [7:0] sel_ptr, dm_opnd_addr, opnd, hi_byte, alu_res, step;
  logic [5:0] in_disp;
  logic [11:0] in_f12;
  logic [14:0] in_f15;

  // the instruction is taken from the port while idle and from its copy afterwards
  assign ins = (state == st_idle) ? instr : cur;
  assign op = ins.op;
  assign pc15 = {pc_upper_byte[6:0], pc_low_byte};
  assign link_addr = pc15 + {13'h0000, ins.len};
  assign sel_ptr = ins.ptr_x ? second_pointer_reg : first_pointer_reg;
  assign is_call = (op == caju_pkg::op_subroutine_call) ||
                   (op == caju_pkg::op_long_subroutine_call);
  assign is_pop = (op == caju_pkg::op_subroutine_exit) ||
                  (op == caju_pkg::op_subroutine_exit_skip);
  assign is_vec = (op == caju_pkg::op_vector_interrupt_select);
  assign src_pm = (ins.mode == caju_pkg::mode_imm) || is_vec ||
                  (op == caju_pkg::op_load_mem_imm) ||
                  (op == caju_pkg::op_table_load_accumulator) ||
                  (op == caju_pkg::op_table_indirect_jump);
  assign needs_rd = src_pm || is_pop || (ins.mode != caju_pkg::mode_none);
  assign take = instr_valid && instr_ready;
  assign skipping = take && skip_pending;
  assign now = take && !skip_pending;
  assign go_rd = now && needs_rd;
  assign go_call = now && is_call && !needs_rd;
  assign go_quick = now && !needs_rd && !is_call;
  assign at1 = (state == st_rd1);
  assign at2 = (state == st_rd2);
  assign atw = (state == st_wr2);
  assign opnd = src_pm_q ? pm_rdata : dm_rdata;
  assign ptr_mod = (ins.mode == caju_pkg::mode_post_inc) ||
                   (ins.mode == caju_pkg::mode_post_dec);
  assign step = (ins.mode == caju_pkg::mode_post_dec) ? ~caju_pkg::ptr_step + 8'h01 :
                caju_pkg::ptr_step;
  assign in_disp = instr.field[5:0];
  assign in_f12 = instr.field[11:0];
  assign in_f15 = instr.field;
  // direct address or the selected pointer
  assign dm_opnd_addr = (ins.mode == caju_pkg::mode_direct) ? ins.field[7:0] : sel_ptr;

  always_comb begin
    if (is_vec) begin
      pm_opnd_addr = ins.field;
    end else if ((op == caju_pkg::op_table_load_accumulator) ||
                 (op == caju_pkg::op_table_indirect_jump)) begin
      // accumulator stands in for the low pc byte only on the address bus
      pm_opnd_addr = {pc_upper_byte[6:0], acc};
    end else begin
      pm_opnd_addr = pc15 + 15'h0001;
    end
  end

  caju_alu u_alu (
    .op(op),
    .a(acc),
    .m(opnd),
    .c_in(carry),
    .hc_in(half_carry),
    .sub_in(last_sub),
    .res(alu_res),
    .c_out(alu_c),
    .hc_out(alu_hc),
    .wr_acc(alu_wr),
    .test(alu_test),
    .cond(alu_cond)
  );

  always_comb begin
    next_pc = pc15;
    if (skipping) begin
      next_pc = link_addr;
    end else if (go_quick) begin
      case (op)
        caju_pkg::op_short_relative_jump:
          next_pc = pc15 + {9'h000, ins.field[5:0]} - caju_pkg::rel_bias;
        caju_pkg::op_absolute_jump_12: next_pc = {pc15[14:12], ins.field[11:0]};
        caju_pkg::op_long_absolute_jump: next_pc = ins.field;
        default: next_pc = link_addr;
      endcase
    end else if (at1) begin
      if (op == caju_pkg::op_table_indirect_jump) begin
        next_pc = {pc15[14:8], opnd};
      end else if (!is_vec && !is_pop) begin
        // low pc byte was never overwritten, so the table read resumes in line
        next_pc = link_addr;
      end
    end else if (at2) begin
      next_pc = {hi_byte[6:0], opnd};
    end else if (atw) begin
      if (op == caju_pkg::op_long_subroutine_call) begin
        next_pc = ins.field;
      end else begin
        next_pc = {pc15[14:12], ins.field[11:0]};
      end
    end
  end

  always_comb begin
    case (state)
      st_idle: next_state = go_rd ? st_rd1 : (go_call ? st_wr2 : st_idle);
      st_rd1: next_state = (is_vec || is_pop) ? st_rd2 : st_idle;
      st_rd2: next_state = st_idle;
      st_wr2: next_state = st_idle;
      default: next_state = st_idle;
    endcase
  end

  // sequencing and hand-in
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= st_idle;
      instr_ready <= 1'b0;
      done <= 1'b0;
      cur <= '0;
      src_pm_q <= 1'b0;
    end else begin
      state <= next_state;
      instr_ready <= (next_state == st_idle);
      done <= skipping || go_quick || (at1 && next_state == st_idle) || at2 || atw;
      if (take) begin
        cur <= instr;
        src_pm_q <= src_pm;
      end
    end
  end

  // program counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_upper_byte <= caju_pkg::pc_upper_reset;
      pc_low_byte <= caju_pkg::pc_low_reset;
    end else begin
      pc_upper_byte <= {1'b0, next_pc[14:8]};
      pc_low_byte <= next_pc[7:0];
    end
  end

  // accumulator and flags
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc <= caju_pkg::acc_reset;
      carry <= 1'b0;
      half_carry <= 1'b0;
      last_sub <= 1'b0;
    end else if (go_quick || at1) begin
      if (alu_wr) acc <= alu_res;
      carry <= alu_c;
      half_carry <= alu_hc;
      // decimal adjust needs to know whether the last carry op was a subtract
      if ((op == caju_pkg::op_add_carry) || (op == caju_pkg::op_subtract_borrow)) begin
        last_sub <= (op == caju_pkg::op_subtract_borrow);
      end
    end
  end

  // skip of the following instruction
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      skip_pending <= 1'b0;
    end else if (skipping) begin
      skip_pending <= 1'b0;
    end else if ((go_quick || at1) && alu_test) begin
      skip_pending <= !alu_cond;
    end else if (at2 && op == caju_pkg::op_subroutine_exit_skip) begin
      skip_pending <= 1'b1;
    end
  end

  // pointer registers; steps wrap and leave the flags alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      first_pointer_reg <= caju_pkg::ptr_reset;
      second_pointer_reg <= caju_pkg::ptr_reset;
    end else if (go_quick && op == caju_pkg::op_load_ptr_short) begin
      first_pointer_reg <= {caju_pkg::short_imm_upper, ins.field[3:0]};
    end else if (at1 && ptr_mod) begin
      if (ins.ptr_x) begin
        second_pointer_reg <= second_pointer_reg + step;
      end else begin
        first_pointer_reg <= first_pointer_reg + step;
      end
    end
  end

  // stack pointer and saved high byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stack_ptr <= caju_pkg::sp_reset;
      hi_byte <= 8'h00;
    end else begin
      if (at1) hi_byte <= opnd;
      if (atw) begin
        stack_ptr <= stack_ptr - caju_pkg::frame_bytes;
      end else if (at2 && is_pop) begin
        stack_ptr <= stack_ptr + caju_pkg::frame_bytes;
      end
    end
  end

  // memory strobes; each strobe lasts one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pm_rd <= 1'b0;
      pm_addr <= 15'h0000;
      dm_req <= '0;
    end else begin
      pm_rd <= 1'b0;
      dm_req.rd <= 1'b0;
      dm_req.we <= 1'b0;
      if (go_rd && src_pm) begin
        pm_rd <= 1'b1;
        pm_addr <= pm_opnd_addr;
      end else if (go_rd) begin
        dm_req.rd <= 1'b1;
        dm_req.addr <= is_pop ? stack_ptr + 8'h01 : dm_opnd_addr;
      end else if (go_call) begin
        // low byte first, so a return reads high then low going upward
        dm_req.we <= 1'b1;
        dm_req.addr <= stack_ptr;
        dm_req.wdata <= link_addr[7:0];
      end else if (atw) begin
        dm_req.we <= 1'b1;
        dm_req.addr <= stack_ptr - 8'h01;
        dm_req.wdata <= {1'b0, link_addr[14:8]};
      end else if (at1) begin
        case (op)
          caju_pkg::op_exchange: begin
            dm_req.we <= 1'b1;
            dm_req.wdata <= acc;
          end
          caju_pkg::op_load_mem_imm: begin
            dm_req.we <= 1'b1;
            dm_req.addr <= dm_opnd_addr;
            dm_req.wdata <= opnd;
          end
          caju_pkg::op_vector_interrupt_select: begin
            pm_rd <= 1'b1;
            pm_addr <= pm_addr + 15'h0001;
          end
          caju_pkg::op_subroutine_exit, caju_pkg::op_subroutine_exit_skip: begin
            dm_req.rd <= 1'b1;
            dm_req.addr <= stack_ptr + caju_pkg::frame_bytes;
          end
          default: ;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  ind_address_a: assert property (go_rd && !src_pm && ins.mode == caju_pkg::mode_indirect
    |=> dm_req.rd && dm_req.addr == $past(sel_ptr)) else $error("pointer address wrong");
  post_step_a: assert property (at1 && ptr_mod && !ins.ptr_x
    |=> first_pointer_reg == $past(first_pointer_reg) + $past(step)) else $error("no step");
  imm_fetch_a: assert property (go_rd && ins.mode == caju_pkg::mode_imm
    |=> pm_rd && pm_addr == $past(pc15) + 15'h0001) else $error("immediate address");
  short_load_a: assert property (go_quick && op == caju_pkg::op_load_ptr_short
    |=> first_pointer_reg[7:4] == 4'h0) else $error("upper nibble kept");
  table_load_a: assert property (go_rd && op == caju_pkg::op_table_load_accumulator
    |=> pm_addr[7:0] == $past(acc) ##1 acc == $past(pm_rdata) &&
    pc_low_byte == $past(pc_low_byte) + 8'h01) else $error("table load");
  pc_msb_a: assert property (pc_upper_byte[7] == 1'b0) else $error("pc msb set");
  rel_jump_a: assert property (go_quick && op == caju_pkg::op_short_relative_jump
    |=> pc15 + 15'h001f == $past(pc15) + {9'h000, $past(in_disp)})
    else $error("relative target");
  abs_jump_a: assert property (go_quick && op == caju_pkg::op_absolute_jump_12
    |=> pc15[14:12] == $past(pc15[14:12]) && pc15[11:0] == $past(in_f12))
    else $error("absolute target");
  long_jump_a: assert property (go_quick && op == caju_pkg::op_long_absolute_jump
    |=> pc15 == $past(in_f15)) else $error("long target");
  ind_jump_a: assert property (go_rd && op == caju_pkg::op_table_indirect_jump
    |=> ##1 pc_upper_byte == $past(pc_upper_byte, 2) && pc_low_byte == $past(pm_rdata))
    else $error("indirect jump");
  skip_next_a: assert property (skipping |=> !skip_pending && done && acc == $past(acc))
    else $error("skipped op acted");
  call_push_a: assert property (go_call |=> dm_req.we ##1 dm_req.we ##1
    stack_ptr == $past(stack_ptr, 2) - 8'h02) else $error("call push");
  rot_right_a: assert property (go_quick && op == caju_pkg::op_rotate_right_carry
    |=> {acc, carry} == {$past(carry), $past(acc)}) else $error("rotate right");
  rot_left_a: assert property (go_quick && op == caju_pkg::op_rotate_left_carry
    |=> {carry, acc} == {$past(acc), $past(carry)}) else $error("rotate left");
  nibble_swap_a: assert property (go_quick && op == caju_pkg::op_swap_nibbles
    |=> {acc[3:0], acc[7:4]} == $past(acc)) else $error("swap");

endmodule // caju_core

// File: caju_mem_model.sv
// program and data memory model standing beside the addressing and jump unit
// assumes reads answer in the strobe cycle and writes land at the clock edge
`timescale 1ns/1ps
module caju_mem_model (
  // clock
  input wire logic clk,
  // program memory
  input wire logic pm_rd,
  input wire logic [14:0] pm_addr,
  output logic [7:0] pm_rdata,
  // data memory
  input wire caju_pkg::caju_dm_req_t dm_req,
  output logic [7:0] dm_rdata
);
  logic [7:0] pm [32768];
  logic [7:0] dm [256];
  logic [7:0] pm_last = 8'h00;
  logic [7:0] dm_last = 8'h00;
  initial begin
    for (int i = 0; i < 32768; i++) pm[i] = 8'(i) ^ 8'(i >> 7) ^ 8'h5a;
    for (int i = 0; i < 256; i++) dm[i] = 8'(i * 37) ^ 8'hc3;
  end
  // an idle bus shows the inverse of the last byte, so a late sample cannot pass by luck
  assign pm_rdata = pm_rd ? pm[pm_addr] : ~pm_last;
  assign dm_rdata = dm_req.rd ? dm[dm_req.addr] : ~dm_last;
  always @(posedge clk) begin
    if (pm_rd) pm_last <= pm[pm_addr];
    if (dm_req.rd) dm_last <= dm[dm_req.addr];
    if (dm_req.we) dm[dm_req.addr] <= dm_req.wdata;
  end
endmodule // caju_mem_model

// File: cpu_addressing_and_jump_unit_tb_top.sv
// self-checking bench for the addressing and jump unit with its memory model
// assumes every instruction completes within a few cycles of being taken
`timescale 1ns/1ps
module cpu_addressing_and_jump_unit_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  caju_pkg::caju_instr_t instr = '0;
  logic instr_ready, done, pm_rd, carry, half_carry, skip_pending;
  logic [14:0] pm_addr;
  logic [7:0] pm_rdata, dm_rdata, acc, first_pointer_reg, second_pointer_reg, stack_ptr;
  logic [7:0] pc_upper_byte, pc_low_byte;
  caju_pkg::caju_dm_req_t dm_req;
  int err_count = 0;
  int checks = 0;
  logic [31:0] seed = 32'h2f3454e2;
  logic [7:0] e_acc = caju_pkg::acc_reset, e_x = 8'h00, e_y = 8'h00, e_sp = caju_pkg::sp_reset;
  logic [14:0] e_pc = 15'h0000;
  logic e_c = 1'b0, e_skip = 1'b0, e_hc = 1'b0, e_sub = 1'b0;
  logic [50:0] exp_q [$];
  caju_pkg::caju_op_t seq [26] = '{caju_pkg::op_clear, caju_pkg::op_decrement,
    caju_pkg::op_xor, caju_pkg::op_load_acc, caju_pkg::op_if_equal, caju_pkg::op_increment,
    caju_pkg::op_if_not_equal, caju_pkg::op_carry_set_op, caju_pkg::op_rotate_right_carry,
    caju_pkg::op_if_carry, caju_pkg::op_rotate_left_carry, caju_pkg::op_if_no_carry,
    caju_pkg::op_swap_nibbles, caju_pkg::op_if_greater, caju_pkg::op_and, caju_pkg::op_or,
    caju_pkg::op_add, caju_pkg::op_if_equal, caju_pkg::op_clear, caju_pkg::op_carry_clear_op,
    caju_pkg::op_if_carry, caju_pkg::op_increment, caju_pkg::op_add_carry,
    caju_pkg::op_decimal_adjust, caju_pkg::op_subtract_borrow, caju_pkg::op_decimal_adjust};

  always #4 clk = ~clk;

  caju_core dut (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .done(done), .pm_rd(pm_rd), .pm_addr(pm_addr),
    .pm_rdata(pm_rdata), .dm_req(dm_req), .dm_rdata(dm_rdata), .acc(acc), .carry(carry),
    .half_carry(half_carry), .first_pointer_reg(first_pointer_reg),
    .second_pointer_reg(second_pointer_reg), .stack_ptr(stack_ptr),
    .pc_upper_byte(pc_upper_byte), .pc_low_byte(pc_low_byte), .skip_pending(skip_pending));
  caju_mem_model mem_i (.clk(clk), .pm_rd(pm_rd), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
    .dm_req(dm_req), .dm_rdata(dm_rdata));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [50:0] state();
    return {acc, carry, half_carry, first_pointer_reg, second_pointer_reg, stack_ptr,
      pc_upper_byte, pc_low_byte, skip_pending};
  endfunction

  function automatic logic [50:0] model();
    return {e_acc, e_c, e_hc, e_x, e_y, e_sp, 1'b0, e_pc, e_skip};
  endfunction

  task automatic chk(input string what, input logic [50:0] seen, input logic [50:0] want);
    checks++;
    if (seen !== want) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // the oldest note belongs to the instruction that completes now
  always @(negedge clk) begin
    if (done === 1'b1) begin
      if (exp_q.size() == 0) chk("spare done", 51'h1, 51'h0);
      else chk("state", state(), exp_q.pop_front());
    end
  end

  task automatic go(input caju_pkg::caju_op_t op, input caju_pkg::caju_mode_t md,
      input logic px, input logic [1:0] len, input logic [14:0] fld);
    int n;
    exp_q.push_back(model());
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= {op, md, px, len, fld};
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (instr_ready !== 1'b1 && n < 20);
    @(posedge clk);
    instr_valid <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 40);
    if (done !== 1'b1) begin
      err_count++;
      end_sim();
    end
  endtask

  // exchange through a pointer, then confirm the old accumulator reached memory
  task automatic xch(input caju_pkg::caju_mode_t md, input logic px);
    logic [7:0] a, old, step;
    a = px ? e_y : e_x;
    old = e_acc;
    e_acc = mem_i.dm[a];
    step = (md == caju_pkg::mode_post_inc) ? 8'h01 :
      (md == caju_pkg::mode_post_dec) ? 8'hff : 8'h00;
    if (px) e_y += step;
    else e_x += step;
    e_pc += 15'h1;
    go(caju_pkg::op_exchange, md, px, 2'h1, 15'h0);
    @(posedge clk);
    #1;
    chk("written byte", {43'h0, mem_i.dm[a]}, {43'h0, old});
  endtask

  task automatic alu(input caju_pkg::caju_op_t op, input logic [7:0] a);
    logic [7:0] m, d, k;
    logic [1:0] len;
    caju_pkg::caju_mode_t md;
    m = mem_i.dm[a];
    md = (op inside {caju_pkg::op_add, caju_pkg::op_and, caju_pkg::op_or, caju_pkg::op_xor,
      caju_pkg::op_load_acc, caju_pkg::op_if_equal, caju_pkg::op_if_not_equal,
      caju_pkg::op_if_greater, caju_pkg::op_add_carry, caju_pkg::op_subtract_borrow})
      ? caju_pkg::mode_direct : caju_pkg::mode_none;
    len = (md == caju_pkg::mode_direct) ? 2'h2 : 2'h1;
    if (e_skip) e_skip = 1'b0;
    else case (op)
      caju_pkg::op_clear: e_acc = 8'h00;
      caju_pkg::op_increment: e_acc += 8'h01;
      caju_pkg::op_decrement: e_acc -= 8'h01;
      caju_pkg::op_add: e_acc += m;
      caju_pkg::op_and: e_acc &= m;
      caju_pkg::op_or: e_acc |= m;
      caju_pkg::op_xor: e_acc ^= m;
      caju_pkg::op_load_acc: e_acc = m;
      caju_pkg::op_carry_set_op: e_c = 1'b1;
      caju_pkg::op_carry_clear_op: e_c = 1'b0;
      caju_pkg::op_add_carry, caju_pkg::op_subtract_borrow: begin
        // carry set after a subtract means no borrow
        d = (op == caju_pkg::op_add_carry) ? m : ~m;
        e_hc = {1'b0, e_acc[3:0]} + {1'b0, d[3:0]} + {4'h0, e_c} > 5'h0f;
        {e_c, e_acc} = {1'b0, e_acc} + {1'b0, d} + {8'h00, e_c};
        e_sub = (op == caju_pkg::op_subtract_borrow);
      end
      caju_pkg::op_decimal_adjust: begin
        // bcd correction, downward after subtract_borrow
        k = {(e_sub ? !e_c : e_c || e_acc > 8'h99) ? 4'h6 : 4'h0,
          (e_sub ? !e_hc : e_hc || e_acc[3:0] > 4'h9) ? 4'h6 : 4'h0};
        if (!e_sub && e_acc > 8'h99) e_c = 1'b1;
        e_acc = e_sub ? e_acc - k : e_acc + k;
      end
      caju_pkg::op_rotate_right_carry: {e_acc, e_c} = {e_c, e_acc};
      caju_pkg::op_rotate_left_carry: {e_c, e_acc} = {e_acc, e_c};
      caju_pkg::op_swap_nibbles: e_acc = {e_acc[3:0], e_acc[7:4]};
      caju_pkg::op_if_equal: e_skip = (e_acc != m);
      caju_pkg::op_if_not_equal: e_skip = (e_acc == m);
      caju_pkg::op_if_greater: e_skip = !(e_acc > m);
      caju_pkg::op_if_carry: e_skip = !e_c;
      caju_pkg::op_if_no_carry: e_skip = e_c;
      default: ;
    endcase
    e_pc += 15'(len);
    go(op, md, 1'b0, len, {7'h0, a});
  endtask

  initial begin
    logic [7:0] t;
    logic [14:0] f, ret, ret2;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("reset", state(), model());
    e_acc = mem_i.pm[e_pc + 15'h1];
    e_pc += 15'h2;
    go(caju_pkg::op_load_acc, caju_pkg::mode_imm, 1'b0, 2'h2, 15'h0);
    xch(caju_pkg::mode_post_dec, 1'b0);
    t = 8'(rnd());
    e_x = {4'h0, t[3:0]};
    e_pc += 15'h1;
    go(caju_pkg::op_load_ptr_short, caju_pkg::mode_none, 1'b0, 2'h1, {11'h0, t[3:0]});
    xch(caju_pkg::mode_post_inc, 1'b0);
    xch(caju_pkg::mode_post_dec, 1'b1);
    xch(caju_pkg::mode_post_inc, 1'b1);
    xch(caju_pkg::mode_indirect, 1'b1);
    t = mem_i.pm[e_pc + 15'h1];
    f = {7'h0, e_x};
    e_x += 8'h01;
    e_pc += 15'h2;
    go(caju_pkg::op_load_mem_imm, caju_pkg::mode_post_inc, 1'b0, 2'h2, 15'h0);
    @(posedge clk);
    #1;
    chk("stored byte", {43'h0, mem_i.dm[f[7:0]]}, {43'h0, t});
    repeat (2) begin
      t = 8'(rnd());
      foreach (seq[i]) alu(seq[i], t);
    end
    f = 15'(rnd());
    e_pc = f;
    go(caju_pkg::op_long_absolute_jump, caju_pkg::mode_none, 1'b0, 2'h3, f);
    e_acc = mem_i.pm[{e_pc[14:8], e_acc}];
    e_pc += 15'h1;
    go(caju_pkg::op_table_load_accumulator, caju_pkg::mode_none, 1'b0, 2'h1, 15'h0);
    f = 15'(rnd());
    e_pc = {e_pc[14:12], f[11:0]};
    go(caju_pkg::op_absolute_jump_12, caju_pkg::mode_none, 1'b0, 2'h2, f);
    for (int c = 0; c < 64; c++) begin
      if (c == 32) continue;
      e_pc = e_pc + 15'(c) - 15'h1f;
      go(caju_pkg::op_short_relative_jump, caju_pkg::mode_none, 1'b0, 2'h1, 15'(c));
    end
    e_pc[7:0] = mem_i.pm[{e_pc[14:8], e_acc}];
    go(caju_pkg::op_table_indirect_jump, caju_pkg::mode_none, 1'b0, 2'h1, 15'h0);
    f = 15'(rnd());
    e_pc = {mem_i.pm[f][6:0], mem_i.pm[f + 15'h1]};
    go(caju_pkg::op_vector_interrupt_select, caju_pkg::mode_none, 1'b0, 2'h1, f);
    ret = e_pc + 15'h3;
    f = 15'(rnd());
    e_pc = f;
    e_sp -= 8'h02;
    go(caju_pkg::op_long_subroutine_call, caju_pkg::mode_none, 1'b0, 2'h3, f);
    @(posedge clk);
    #1;
    f = {mem_i.dm[e_sp + 8'h01][6:0], mem_i.dm[e_sp + 8'h02]};
    chk("pushed pc", {36'h0, f}, {36'h0, ret});
    ret2 = e_pc + 15'h2;
    f = 15'(rnd());
    e_pc = {e_pc[14:12], f[11:0]};
    e_sp -= 8'h02;
    go(caju_pkg::op_subroutine_call, caju_pkg::mode_none, 1'b0, 2'h2, f);
    e_pc = ret2;
    e_sp += 8'h02;
    go(caju_pkg::op_subroutine_exit, caju_pkg::mode_none, 1'b0, 2'h1, 15'h0);
    e_pc = ret;
    e_sp += 8'h02;
    e_skip = 1'b1;
    go(caju_pkg::op_subroutine_exit_skip, caju_pkg::mode_none, 1'b0, 2'h1, 15'h0);
    alu(caju_pkg::op_clear, 8'h00);
    // let the watcher take the last note before counting leftovers
    @(negedge clk);
    chk("notes left", 51'(exp_q.size()), 51'h0);
    end_sim();
  end
endmodule // cpu_addressing_and_jump_unit_tb_top
